// [rtl/dnv_target.sv]
// Two-wire target port with a nonvolatile setpoint word that loads the DAC at power-up.
`timescale 1ns/10ps
module dnv_target #(
    parameter logic FIXED_HIGH = dnv_pkg::FIXED_HIGH_RST,
    parameter logic FIXED_MID = dnv_pkg::FIXED_MID_RST
) (
    input wire logic mclk_in,                               // Main clock, 25 MHz.
    input wire logic reset_n_in,                            // Power-on reset, active low.
    input wire logic link_clk_in,                           // Sampling clock of the link.
    input wire logic scl_in,                                // Bus clock line level.
    output logic scl_out,                                   // Bus clock drive value, always 0.
    output logic scl_oe_out,                                // Bus clock pull-down, never on.
    input wire logic sda_in,                                // Bus data line level.
    output logic sda_out,                                   // Bus data drive value, always 0.
    output logic sda_oe_out,                                // High while pulling data low.
    input wire logic addr_strap_pin_in,                     // Address strap pin.
    output logic [dnv_pkg::CODE_W-1:0] dac_code_out,        // DAC register code.
    output logic [dnv_pkg::PD_W-1:0] pd_mode_out,           // Power-down mode bits.
    output logic ready_out                                  // High once the power-up load is done.
);
    dnv_pkg::dnv_link_t l_q, l_d;
    dnv_pkg::dnv_main_t m_q, m_d;
    // Nonvolatile word; it has no reset so its contents survive a power-on reset.
    // The initial value stands for blank memory as shipped, so a fresh part loads zero.
    logic [dnv_pkg::WORD_W-1:0] nv_mem = dnv_pkg::WORD_RST;
    logic nv_we;
    logic scl_rise, scl_fall, start_c, stop_c, addr_hit;

    // Picks byte 0 ({00, pd, code high}) or byte 1 (code low) of a stored word.
    function automatic logic [7:0] byte_of(input logic [dnv_pkg::WORD_W-1:0] w,
                                           input logic idx);
        logic [7:0] b;
        b = idx ? w[7:0] : {2'h0, w[dnv_pkg::WORD_W-1:8]};
        return b;
    endfunction

    // Line events, seen only on the second synchroniser stage and its delayed copy.
    assign scl_rise = l_q.scl_s2 & ~l_q.scl_p;
    assign scl_fall = ~l_q.scl_s2 & l_q.scl_p;
    assign start_c = l_q.scl_s2 & l_q.scl_p & l_q.sda_p & ~l_q.sda_s2;
    assign stop_c = l_q.scl_s2 & l_q.scl_p & ~l_q.sda_p & l_q.sda_s2;
    assign addr_hit = (l_q.shreg[7:1] == {dnv_pkg::ADDR_BASE, FIXED_HIGH, FIXED_MID,
                                          l_q.stp_s2});

    // Link engine: shifts bytes on clock edges, acknowledges, and answers reads.
    always_comb begin
        l_d = l_q;
        l_d.scl_s1 = scl_in;
        l_d.scl_s2 = l_q.scl_s1;
        l_d.scl_p = l_q.scl_s2;
        l_d.sda_s1 = sda_in;
        l_d.sda_s2 = l_q.sda_s1;
        l_d.sda_p = l_q.sda_s2;
        l_d.stp_s1 = addr_strap_pin_in;
        l_d.stp_s2 = l_q.stp_s1;
        l_d.rtg_s1 = m_q.rd_tgl;
        l_d.rtg_s2 = l_q.rtg_s1;
        l_d.rtg_p = l_q.rtg_s2;
        l_d.zero = 1'b0;
        // The main side holds its word steady for many link cycles after each toggle.
        if (l_q.rtg_s2 != l_q.rtg_p) begin
            l_d.rd_copy = m_q.rd_word;
        end
        if (start_c) begin
            l_d.st = dnv_pkg::L_ADDR;
            l_d.bitcnt = 4'h0;
            l_d.byte_idx = 1'b0;
            l_d.sda_oe = 1'b0;
        end else if (stop_c) begin
            l_d.st = dnv_pkg::L_IDLE;
            l_d.sda_oe = 1'b0;
        end else begin
            case (l_q.st)
                dnv_pkg::L_ADDR, dnv_pkg::L_WR: begin
                    if (scl_rise) begin
                        l_d.shreg = {l_q.shreg[6:0], l_q.sda_s2};
                        l_d.bitcnt = l_q.bitcnt + 4'h1;
                    end else if (scl_fall && l_q.bitcnt == dnv_pkg::BYTE_BITS) begin
                        l_d.bitcnt = 4'h0;
                        if (l_q.st == dnv_pkg::L_ADDR) begin
                            // Only a matching address is acknowledged.
                            l_d.st = addr_hit ? dnv_pkg::L_AACK : dnv_pkg::L_IDLE;
                            l_d.sda_oe = addr_hit;
                            l_d.is_rd = l_q.shreg[0];
                        end else begin
                            l_d.st = dnv_pkg::L_WACK;
                            l_d.sda_oe = 1'b1;
                            l_d.byte_idx = ~l_q.byte_idx;
                            if (!l_q.byte_idx) begin
                                l_d.hi = l_q.shreg[5:0];
                            end else begin
                                l_d.wr_word = {l_q.hi, l_q.shreg};
                                l_d.wr_tgl = ~l_q.wr_tgl;
                            end
                        end
                    end
                end
                dnv_pkg::L_AACK: begin
                    if (scl_fall) begin
                        if (l_q.is_rd) begin
                            l_d.st = dnv_pkg::L_RD;
                            l_d.shreg = byte_of(l_q.rd_copy, 1'b0);
                            l_d.sda_oe = ~l_d.shreg[7];
                        end else begin
                            l_d.st = dnv_pkg::L_WR;
                            l_d.sda_oe = 1'b0;
                        end
                    end
                end
                dnv_pkg::L_WACK: begin
                    if (scl_fall) begin
                        l_d.st = dnv_pkg::L_WR;
                        l_d.sda_oe = 1'b0;
                    end
                end
                dnv_pkg::L_RD: begin
                    if (scl_rise) begin
                        l_d.bitcnt = l_q.bitcnt + 4'h1;
                    end else if (scl_fall) begin
                        if (l_q.bitcnt == dnv_pkg::BYTE_BITS) begin
                            l_d.st = dnv_pkg::L_RACK;
                            l_d.sda_oe = 1'b0;
                        end else begin
                            l_d.shreg = {l_q.shreg[6:0], 1'b0};
                            l_d.sda_oe = ~l_q.shreg[6];
                        end
                    end
                end
                dnv_pkg::L_RACK: begin
                    // A not-acknowledge ends the read; the master then sends stop.
                    if (scl_rise && l_q.sda_s2) begin
                        l_d.st = dnv_pkg::L_IDLE;
                    end else if (scl_fall) begin
                        l_d.st = dnv_pkg::L_RD;
                        l_d.bitcnt = 4'h0;
                        l_d.byte_idx = ~l_q.byte_idx;
                        l_d.shreg = byte_of(l_q.rd_copy, ~l_q.byte_idx);
                        l_d.sda_oe = ~l_d.shreg[7];
                    end
                end
                default: begin
                    l_d.sda_oe = 1'b0;
                end
            endcase
        end
    end

    // Link registers.
    always_ff @(posedge link_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            l_q <= '{st: dnv_pkg::L_IDLE, scl_s1: 1'b1, scl_s2: 1'b1, scl_p: 1'b1,
                     sda_s1: 1'b1, sda_s2: 1'b1, sda_p: 1'b1, default: '0};
        end else begin
            l_q <= l_d;
        end
    end

    // Main side: power-up load, then applies and stores each written word.
    always_comb begin
        m_d = m_q;
        nv_we = 1'b0;
        m_d.wtg_s1 = l_q.wr_tgl;
        m_d.wtg_s2 = m_q.wtg_s1;
        m_d.wtg_p = m_q.wtg_s2;
        case (m_q.st)
            dnv_pkg::M_LOAD: begin
                m_d.code = nv_mem[dnv_pkg::CODE_W-1:0];
                m_d.pd = nv_mem[dnv_pkg::PD_POS +: dnv_pkg::PD_W];
                m_d.rd_word = nv_mem;
                m_d.rd_tgl = ~m_q.rd_tgl;
                m_d.ready = 1'b1;
                m_d.st = dnv_pkg::M_RUN;
            end
            default: begin
                // The link word is stable from its toggle until the next byte pair ends.
                if (m_q.wtg_s2 != m_q.wtg_p) begin
                    nv_we = 1'b1;
                    m_d.code = l_q.wr_word[dnv_pkg::CODE_W-1:0];
                    m_d.pd = l_q.wr_word[dnv_pkg::PD_POS +: dnv_pkg::PD_W];
                    m_d.rd_word = l_q.wr_word;
                    m_d.rd_tgl = ~m_q.rd_tgl;
                end
            end
        endcase
    end

    // Main registers.
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            m_q <= '{st: dnv_pkg::M_LOAD, code: dnv_pkg::CODE_RST, pd: dnv_pkg::PD_RST,
                     rd_word: dnv_pkg::WORD_RST, default: '0};
        end else begin
            m_q <= m_d;
        end
    end

    // Nonvolatile store, deliberately outside the reset so it outlives power loss.
    always_ff @(posedge mclk_in) begin
        if (nv_we) begin
            nv_mem <= l_q.wr_word;
        end
    end

    assign scl_out = l_q.zero;
    assign scl_oe_out = l_q.zero;
    assign sda_out = l_q.zero;
    assign sda_oe_out = l_q.sda_oe;
    assign dac_code_out = m_q.code;
    assign pd_mode_out = m_q.pd;
    assign ready_out = m_q.ready;

    // Link-side checks.
    AST_STRAP_MISS: assert property (@(posedge link_clk_in) disable iff (!reset_n_in)
        l_q.st == dnv_pkg::L_ADDR && scl_fall && !start_c && !stop_c
        && l_q.bitcnt == dnv_pkg::BYTE_BITS && l_q.shreg[1] != l_q.stp_s2
        |=> l_q.st == dnv_pkg::L_IDLE && !sda_oe_out)
        else $error("Address with wrong strap bit was accepted.");
    AST_ACK_PULL: assert property (@(posedge link_clk_in) disable iff (!reset_n_in)
        l_q.st == dnv_pkg::L_ADDR && scl_fall && !start_c && !stop_c
        && l_q.bitcnt == dnv_pkg::BYTE_BITS && addr_hit
        |=> sda_oe_out && l_q.st == dnv_pkg::L_AACK)
        else $error("Matching address was not acknowledged.");
    AST_ACK_RELEASE: assert property (@(posedge link_clk_in) disable iff (!reset_n_in)
        l_q.st == dnv_pkg::L_AACK && scl_fall && !l_q.is_rd && !start_c && !stop_c
        |=> !sda_oe_out)
        else $error("Data line not released after acknowledge.");
    AST_RESTART: assert property (@(posedge link_clk_in) disable iff (!reset_n_in)
        start_c |=> l_q.st == dnv_pkg::L_ADDR && l_q.bitcnt == 4'h0 && !sda_oe_out)
        else $error("Start condition did not restart address phase.");
    AST_STOP_IDLE: assert property (@(posedge link_clk_in) disable iff (!reset_n_in)
        stop_c && !start_c |=> l_q.st == dnv_pkg::L_IDLE && !sda_oe_out)
        else $error("Stop condition did not end the transfer.");
    AST_OPEN_DRAIN: assert property (@(posedge link_clk_in) disable iff (!reset_n_in)
        !sda_out && !scl_oe_out && !scl_out)
        else $error("A bus line is driven high or the clock is pulled.");
    // Data phase and idle checks: the pull follows the byte being sent and frees the line for answers.
    AST_WR_ACK: assert property (@(posedge link_clk_in) disable iff (!reset_n_in)
        l_q.st == dnv_pkg::L_WR && scl_fall && !start_c && !stop_c
        && l_q.bitcnt == dnv_pkg::BYTE_BITS |=> sda_oe_out && l_q.st == dnv_pkg::L_WACK)
        else $error("Data byte was not acknowledged.");
    AST_PAIR_ONLY: assert property (@(posedge link_clk_in) disable iff (!reset_n_in)
        $changed(l_q.wr_tgl) |-> $past(l_q.byte_idx) && $past(l_q.st) == dnv_pkg::L_WR)
        else $error("A word was handed over without a full byte pair.");
    AST_READ_BIT: assert property (@(posedge link_clk_in) disable iff (!reset_n_in)
        l_q.st == dnv_pkg::L_RD && scl_fall && !start_c && !stop_c
        && l_q.bitcnt != dnv_pkg::BYTE_BITS |=> sda_oe_out == !l_q.shreg[7])
        else $error("Read data line does not follow the byte being sent.");
    AST_RACK_FREE: assert property (@(posedge link_clk_in) disable iff (!reset_n_in)
        l_q.st == dnv_pkg::L_RACK |-> !sda_oe_out)
        else $error("Data line held during the answer of the master.");
    AST_IDLE_FREE: assert property (@(posedge link_clk_in) disable iff (!reset_n_in)
        l_q.st == dnv_pkg::L_IDLE |-> !sda_oe_out)
        else $error("Data line pulled while the port is idle.");

    // Main-side checks.
    AST_NV_STORE: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        m_q.st == dnv_pkg::M_RUN && m_q.wtg_s2 != m_q.wtg_p
        |=> nv_mem == $past(l_q.wr_word) && {pd_mode_out, dac_code_out} == nv_mem)
        else $error("Written word not stored in nonvolatile memory.");
    AST_READ_SRC: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        $changed(m_q.rd_tgl) |-> m_q.rd_word == nv_mem)
        else $error("Read word differs from nonvolatile contents.");
    AST_POWERUP_LOAD: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        $rose(ready_out) |-> dac_code_out == nv_mem[dnv_pkg::CODE_W-1:0]
        && pd_mode_out == nv_mem[dnv_pkg::PD_POS +: dnv_pkg::PD_W])
        else $error("Power-up load did not copy the stored word.");
    AST_LOAD_TIME: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        m_q.st == dnv_pkg::M_LOAD |=> ready_out ##1 ready_out)
        else $error("Power-up load took longer than one cycle.");
    // Once loaded, the outputs move only when a full word is stored.
    AST_READY_HOLD: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        ready_out |=> ready_out)
        else $error("Ready dropped without a reset.");
    AST_LOAD_ONCE: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        m_q.st == dnv_pkg::M_RUN |=> m_q.st == dnv_pkg::M_RUN)
        else $error("Power-up load repeated without a reset.");
    AST_DAC_HOLD: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        m_q.st == dnv_pkg::M_RUN && !nv_we
        |=> $stable(dac_code_out) && $stable(pd_mode_out))
        else $error("DAC outputs moved without a stored word.");

    COV_ADDR_ACK: cover property (@(posedge link_clk_in) disable iff (!reset_n_in)
        l_q.st == dnv_pkg::L_AACK && l_q.is_rd);
    COV_WRITE: cover property (@(posedge mclk_in) disable iff (!reset_n_in) nv_we);
    COV_READ_BYTE2: cover property (@(posedge link_clk_in) disable iff (!reset_n_in)
        l_q.st == dnv_pkg::L_RD && l_q.byte_idx);
    COV_RESTART: cover property (@(posedge link_clk_in) disable iff (!reset_n_in)
        start_c && l_q.st != dnv_pkg::L_IDLE);
endmodule

// [pkg/dnv_pkg.sv]
// Shared constants, states and state records of the nonvolatile setpoint target port.
package dnv_pkg;
    // Upper four address bits that precede the two fixed bits and the strap bit.
    localparam logic [3:0] ADDR_BASE = 4'hc;
    // Fixed address bits; the values here are arbitrary defaults.
    localparam logic FIXED_HIGH_RST = 1'b0;
    localparam logic FIXED_MID_RST = 1'b0;
    // Bits in one byte, and the stored word layout {power-down[1:0], code[11:0]}.
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam int CODE_W = 12;
    localparam int PD_W = 2;
    localparam int WORD_W = CODE_W + PD_W;
    localparam int PD_POS = CODE_W;
    // Reset values of the output registers.
    localparam logic [CODE_W-1:0] CODE_RST = 12'h000;
    localparam logic [PD_W-1:0] PD_RST = 2'h0;
    localparam logic [WORD_W-1:0] WORD_RST = 14'h0000;

    typedef enum logic [2:0] {
        L_IDLE, L_ADDR, L_AACK, L_WR, L_WACK, L_RD, L_RACK
    } dnv_lstate_t;

    typedef enum logic {M_LOAD, M_RUN} dnv_mstate_t;

    // State of the logic on the link clock.
    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_p;
        logic sda_s1;
        logic sda_s2;
        logic sda_p;
        logic stp_s1;
        logic stp_s2;
        logic rtg_s1;
        logic rtg_s2;
        logic rtg_p;
        dnv_lstate_t st;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic byte_idx;
        logic is_rd;
        logic [5:0] hi;
        logic [WORD_W-1:0] wr_word;
        logic wr_tgl;
        logic [WORD_W-1:0] rd_copy;
        logic sda_oe;
        logic zero;
    } dnv_link_t;

    // State of the logic on the main clock.
    typedef struct packed {
        dnv_mstate_t st;
        logic wtg_s1;
        logic wtg_s2;
        logic wtg_p;
        logic [CODE_W-1:0] code;
        logic [PD_W-1:0] pd;
        logic [WORD_W-1:0] rd_word;
        logic rd_tgl;
        logic ready;
    } dnv_main_t;
endpackage

// [testbench/dnv_master_bfm.sv]
// Two-wire bus master model that reaches the target port through open-drain lines.
`timescale 1ns/10ps
module dnv_master_bfm (
    input wire logic clk_in,           // Pacing clock for the bus steps.
    input wire logic sda_in,           // Resolved bus data line.
    output logic scl_oe_out,           // High while pulling the clock line low.
    output logic sda_oe_out,           // High while pulling the data line low.
    output logic [7:0] obs_val_out,    // Last acknowledge bit or read byte.
    output logic obs_tgl_out           // Toggles when a new observation is posted.
);
    // Lines start released, so the bus clock stands still between frames.
    initial begin
        scl_oe_out = 1'b0;
        sda_oe_out = 1'b0;
        obs_val_out = 8'h00;
        obs_tgl_out = 1'b0;
    end

    // One quarter bit; it spans many link samples, so every level is seen by the sync flops.
    task automatic put(input logic c, input logic d);
        scl_oe_out = ~c;
        sda_oe_out = ~d;
        repeat (4) @(posedge clk_in);
        #3;
    endtask

    task automatic post(input logic [7:0] v);
        obs_val_out = v;
        obs_tgl_out = ~obs_tgl_out;
    endtask

    // Start and repeated start alike; each step moves only one line to avoid false conditions.
    task automatic start;
        put(1'b0, 1'b1);
        put(1'b1, 1'b1);
        put(1'b1, 1'b0);
        put(1'b0, 1'b0);
    endtask

    task automatic stop;
        put(1'b0, 1'b0);
        put(1'b1, 1'b0);
        put(1'b1, 1'b1);
    endtask

    task automatic wbit(input logic b);
        put(1'b0, b);
        put(1'b1, b);
        put(1'b1, b);
        put(1'b0, b);
    endtask

    task automatic rbit(output logic v);
        put(1'b0, 1'b1);
        put(1'b1, 1'b1);
        v = sda_in;
        put(1'b1, 1'b1);
        put(1'b0, 1'b1);
    endtask

    // Sends a byte and posts the acknowledge bit, 0 meaning acknowledged.
    task automatic wbyte(input logic [7:0] b);
        logic a;
        for (int i = 7; i >= 0; i--) wbit(b[i]);
        rbit(a);
        post({7'h00, a});
    endtask

    // Reads a byte and answers it; a high last bit ends the read with a refusal.
    task automatic rbyte(input logic last);
        logic [7:0] b;
        for (int i = 7; i >= 0; i--) rbit(b[i]);
        wbit(last);
        post(b);
    endtask
endmodule

// [testbench/dac_i2c_nv_setpoint_port_tb.sv]
// Self-checking testbench of the nonvolatile setpoint target port.
`timescale 1ns/10ps
module dac_i2c_nv_setpoint_port_tb;
    localparam logic FIX_HI = 1'b1;
    localparam logic FIX_MID = 1'b0;
    logic mclk = 1'b0;
    logic link_clk = 1'b0;
    logic reset_n;
    logic strap;
    logic m_scl_oe, m_sda_oe, d_scl_out, d_scl_oe, d_sda_out, d_sda_oe, ready, obs_tgl;
    logic [7:0] obs_val;
    logic [11:0] dac_code, code;
    logic [1:0] pd_mode, pd, top;
    logic [7:0] exp_q[$];
    int n_mismatch = 0;
    int comparisons = 0;
    int seed;
    wire scl_w;
    wire sda_w;

    // Pull-ups win unless some party pulls a line low.
    assign scl_w = !(m_scl_oe || d_scl_oe);
    assign sda_w = !(m_sda_oe || d_sda_oe);

    // The link clock has no phase relation to the main clock.
    always #20 mclk = ~mclk;
    always #7.5 link_clk = ~link_clk;

    dnv_target #(.FIXED_HIGH(FIX_HI), .FIXED_MID(FIX_MID)) i_dut (.mclk_in(mclk),
        .reset_n_in(reset_n), .link_clk_in(link_clk), .scl_in(scl_w), .scl_out(d_scl_out),
        .scl_oe_out(d_scl_oe), .sda_in(sda_w), .sda_out(d_sda_out), .sda_oe_out(d_sda_oe),
        .addr_strap_pin_in(strap), .dac_code_out(dac_code), .pd_mode_out(pd_mode),
        .ready_out(ready));

    dnv_master_bfm i_mst (.clk_in(mclk), .sda_in(sda_w), .scl_oe_out(m_scl_oe),
        .sda_oe_out(m_sda_oe), .obs_val_out(obs_val), .obs_tgl_out(obs_tgl));

    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic test_done;
        $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    function automatic logic [7:0] adr(input logic s, input logic rd);
        return {dnv_pkg::ADDR_BASE, FIX_HI, FIX_MID, s, rd};
    endfunction

    // Waits a bounded time for the DAC outputs to take a value, then compares.
    task automatic wait_dac(input logic [15:0] e);
        int n = 0;
        while ({1'b0, ready, pd_mode, dac_code} !== e && n < 50) begin
            @(posedge mclk);
            n++;
        end
        #3;
        chk(e, {1'b0, ready, pd_mode, dac_code});
    endtask

    // Every bus result is matched against the oldest expectation noted by the driver.
    // The short wait lets the value settle; the start-up step from unknown is no result.
    always @(obs_tgl) begin
        #1;
        if ($time > 1) begin
            if (exp_q.size() == 0) begin
                chk(16'hffff, {8'h00, obs_val});
            end else begin
                chk({8'h00, exp_q.pop_front()}, {8'h00, obs_val});
            end
        end
    end

    // The clock line is never pulled and nothing is ever driven high.
    always @(posedge mclk) begin
        if (reset_n) chk(16'h0000, {13'h0000, d_scl_oe, d_scl_out, d_sda_out});
    end

    task automatic read_back;
        exp_q.push_back(8'h00);
        exp_q.push_back({2'b00, pd, code[11:8]});
        exp_q.push_back(code[7:0]);
        i_mst.wbyte(adr(1'b1, 1'b1));
        i_mst.rbyte(1'b0);
        i_mst.rbyte(1'b1);
        i_mst.stop();
    endtask

    initial begin
        reset_n = 1'b0;
        strap = 1'b0;
        seed = $urandom(32'hb9ac898f);
        repeat (20) @(posedge mclk);
        #3;
        chk(16'h0000, {1'b0, ready, pd_mode, dac_code});
        reset_n = 1'b1;
        repeat (8) @(posedge mclk);
        #3;
        // A fresh part loads its blank stored word and reports ready.
        chk({2'b01, dnv_pkg::WORD_RST}, {1'b0, ready, pd_mode, dac_code});
        // Presence probes at both strap levels; only the matching address answers.
        for (int s = 0; s < 2; s++) begin
            strap = s[0];
            for (int a = 0; a < 2; a++) begin
                exp_q.push_back((a == s) ? 8'h00 : 8'h01);
                i_mst.start();
                i_mst.wbyte(adr(a[0], 1'b0));
                i_mst.stop();
            end
        end
        // Every power-down mode, with random ignored top bits, then read back after restart.
        for (int m = 0; m < 4; m++) begin
            code = 12'($urandom());
            top = 2'($urandom());
            pd = m[1:0];
            repeat (3) exp_q.push_back(8'h00);
            i_mst.start();
            i_mst.wbyte(adr(1'b1, 1'b0));
            i_mst.wbyte({top, pd, code[11:8]});
            i_mst.wbyte(code[7:0]);
            i_mst.start();
            read_back();
            wait_dac({2'b01, pd, code});
        end
        // A lone first byte must store nothing.
        repeat (2) exp_q.push_back(8'h00);
        i_mst.start();
        i_mst.wbyte(adr(1'b1, 1'b0));
        i_mst.wbyte(8'h3f);
        i_mst.stop();
        repeat (20) @(posedge mclk);
        #3;
        chk({2'b01, pd, code}, {1'b0, ready, pd_mode, dac_code});
        // Power cycle: outputs clear, then the stored word reloads with its mode bits.
        reset_n = 1'b0;
        repeat (4) @(posedge mclk);
        #3;
        chk(16'h0000, {1'b0, ready, pd_mode, dac_code});
        reset_n = 1'b1;
        repeat (2) @(posedge mclk);
        #3;
        chk({2'b01, pd, code}, {1'b0, ready, pd_mode, dac_code});
        repeat (8) @(posedge mclk);
        #3;
        i_mst.start();
        read_back();
        chk(16'h0000, 16'(exp_q.size()));
        test_done();
    end
endmodule
